// file: pkg/pcp_pkg.sv
// constants and types of the program counter and pointer block
// Function
// - 11-bit counter, 3-bit upper, 8-bit low byte
// - advance counter by one per instruction
// - jump or call loads bits 0 to 10
// - nine skip instructions advance by two when true
// - bit test skips on matching bit value
// - compare skip when accumulator equals operand
// - increment skip when result wraps to zero
// - decrement skip when one goes to zero
// - add into low byte carries into upper
// - subtract into low byte never borrows upper
// - move into low byte jumps, upper kept
// - first pair: location 080h, bank 081h
// - first indirect port addresses bank and location
// - second pair: bank 084h, location 083h
// - second indirect port addresses bank and location
// - second pair addresses program memory table reads
// - table read: high to buffer, low to accumulator
`default_nettype none
package pcp_pkg;
	localparam int PC_W   = 11;
	localparam int PCH_W  = 3;
	localparam int BYTE_W = 8;
	localparam int BIT_W  = 3;
	localparam int ROM_W  = 16;
	// register offsets
	localparam logic [7:0] FIRST_LOC_OFF  = 8'h80;
	localparam logic [7:0] FIRST_BANK_OFF = 8'h81;
	localparam logic [7:0] SECOND_LOC_OFF  = 8'h83;
	localparam logic [7:0] SECOND_BANK_OFF = 8'h84;
	localparam logic [7:0] PC_LOW_OFF  = 8'hce;
	localparam logic [7:0] PC_HIGH_OFF = 8'hcf;
	// reset values, step sizes and skip compare values
	localparam logic [PC_W-1:0] PC_RESET = 11'h000;
	localparam logic [PC_W-1:0] PC_STEP  = 11'h001;
	localparam logic [PC_W-1:0] PC_SKIP  = 11'h002;
	localparam logic [PCH_W-1:0] PCH_STEP = 3'h1;
	localparam logic [7:0] WRAP_FROM = 8'hff;
	localparam logic [7:0] DEC_FROM  = 8'h01;

	typedef enum logic [2:0] {
		OP_HOLD, OP_NEXT, OP_JUMP, OP_SKIP, OP_ADD_PCL, OP_SUB_PCL, OP_TABLE
	} pcp_op_t;

	typedef enum logic [3:0] {
		SK_CMP, SK_INC_ACC, SK_INC_MEM, SK_DEC_ACC, SK_DEC_MEM,
		SK_BIT_CLR, SK_BIT_SET, SK_B0_BIT_CLR, SK_B0_BIT_SET
	} pcp_skip_t;

	typedef struct packed {
		pcp_op_t           kind;
		pcp_skip_t         skip;
		logic [PC_W-1:0]   target;
		logic [BYTE_W-1:0] operand;
		logic [BYTE_W-1:0] acc;
		logic [BIT_W-1:0]  bit_sel;
		logic              carry_in;
	} pcp_cmd_t;

	typedef struct packed {
		logic [BYTE_W-1:0] bank;
		logic [BYTE_W-1:0] loc;
	} pcp_ptr_t;

	typedef struct packed {
		logic [BYTE_W-1:0] data;
		logic              to_acc;
		logic              to_mem;
	} pcp_res_t;

	typedef struct packed {
		logic [BYTE_W-1:0] high;
		logic [BYTE_W-1:0] low;
		logic              valid;
	} pcp_tbl_t;
endpackage : pcp_pkg
`default_nettype wire

// file: logic/pcp_core.sv
// program counter, skip logic, data pointers and table read
//
// Design decision made here: the strobed register port.
`default_nettype none
module pcp_core
(
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire pcp_pkg::pcp_cmd_t          cmd,
	input  wire logic [7:0]                 reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	input  wire logic [pcp_pkg::ROM_W-1:0]  rom_data,
	output logic [7:0]                      reg_rdata,
	output logic [pcp_pkg::PC_W-1:0]        pc,
	output logic                            skip_taken,
	output pcp_pkg::pcp_res_t               result,
	output pcp_pkg::pcp_ptr_t               first_indirect_port,
	output pcp_pkg::pcp_ptr_t               second_indirect_port,
	output logic [pcp_pkg::ROM_W-1:0]       rom_addr,
	output logic                            rom_rd,
	output pcp_pkg::pcp_tbl_t               table_out
);
	import pcp_pkg::*;

	// ============================================================
	// state
	logic [PC_W-1:0]    pc_reg;
	logic [PC_W-1:0]    pc_next;
	logic               skip_reg;
	pcp_res_t           res_reg;
	pcp_ptr_t           first_reg;
	pcp_ptr_t           second_reg;
	logic [ROM_W-1:0]   rom_addr_reg;
	logic               rom_rd_reg;
	pcp_tbl_t           tbl_reg;
	logic [7:0]         rdata_reg;

	logic               wr_pcl;
	logic               wr_pch;
	logic               skip_hit;
	logic [BYTE_W-1:0]  inc_val;
	logic [BYTE_W-1:0]  dec_val;
	logic [BYTE_W:0]    add_sum;
	logic [BYTE_W:0]    sub_diff;
	logic               is_skip;

	assign wr_pcl  = reg_wr && (reg_addr == PC_LOW_OFF);
	assign wr_pch  = reg_wr && (reg_addr == PC_HIGH_OFF);
	assign is_skip = (cmd.kind == OP_SKIP);
	assign inc_val = cmd.operand + 8'h01;
	assign dec_val = cmd.operand - 8'h01;
	assign add_sum = {1'b0, pc_reg[7:0]} + {1'b0, cmd.operand} + {8'h00, cmd.carry_in};
	assign sub_diff = {1'b0, pc_reg[7:0]} - {1'b0, cmd.operand} - {8'h00, ~cmd.carry_in};

	// ============================================================
	// skip conditions
	always_comb
	begin
		unique case (cmd.skip)
			SK_CMP:
				skip_hit = (cmd.acc == cmd.operand);
			SK_INC_ACC, SK_INC_MEM:
				skip_hit = (cmd.operand == WRAP_FROM);
			SK_DEC_ACC, SK_DEC_MEM:
				skip_hit = (cmd.operand == DEC_FROM);
			SK_BIT_SET, SK_B0_BIT_SET:
				skip_hit = cmd.operand[cmd.bit_sel];
			SK_BIT_CLR, SK_B0_BIT_CLR:
				skip_hit = ~cmd.operand[cmd.bit_sel];
			default:
				skip_hit = 1'b0;
		endcase
	end

	// ============================================================
	// program counter next value
	always_comb
	begin
		pc_next = pc_reg;
		if (wr_pcl)
		begin
			pc_next = {pc_reg[PC_W-1:8], reg_wdata};
		end
		else if (wr_pch)
		begin
			pc_next = {reg_wdata[PCH_W-1:0], pc_reg[7:0]};
		end
		else
		begin
			unique case (cmd.kind)
				OP_HOLD:
					pc_next = pc_reg;
				OP_NEXT, OP_TABLE:
					pc_next = pc_reg + PC_STEP;
				OP_JUMP:
					pc_next = cmd.target;
				OP_SKIP:
					pc_next = pc_reg + (skip_hit ? PC_SKIP : PC_STEP);
				OP_ADD_PCL:
					pc_next = {pc_reg[PC_W-1:8] + (add_sum[BYTE_W] ? PCH_STEP : 3'h0),
						add_sum[BYTE_W-1:0]};
				OP_SUB_PCL:
					pc_next = {pc_reg[PC_W-1:8], sub_diff[BYTE_W-1:0]};
				default:
					pc_next = pc_reg;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			pc_reg <= PC_RESET;
		else
			pc_reg <= pc_next;
	end

	// ============================================================
	// skip flag and inc/dec result
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			skip_reg <= 1'b0;
		else
			skip_reg <= is_skip && skip_hit && !reg_wr;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			res_reg <= '0;
		end
		else
		begin
			res_reg.to_acc <= is_skip && (cmd.skip == SK_INC_ACC || cmd.skip == SK_DEC_ACC);
			res_reg.to_mem <= is_skip && (cmd.skip == SK_INC_MEM || cmd.skip == SK_DEC_MEM);
			if (cmd.skip == SK_INC_ACC || cmd.skip == SK_INC_MEM)
				res_reg.data <= inc_val;
			else
				res_reg.data <= dec_val;
		end
	end

	// ============================================================
	// pointer pairs, no reset: contents undefined until written
	always_ff @(posedge clk)
	begin
		if (reg_wr)
		begin
			unique case (reg_addr)
				FIRST_LOC_OFF:   first_reg.loc   <= reg_wdata;
				FIRST_BANK_OFF:  first_reg.bank  <= reg_wdata;
				SECOND_LOC_OFF:  second_reg.loc  <= reg_wdata;
				SECOND_BANK_OFF: second_reg.bank <= reg_wdata;
				default:         ;
			endcase
		end
	end

	// ============================================================
	// table read: fetch at second pair, then split the word
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rom_addr_reg <= '0;
			rom_rd_reg   <= 1'b0;
		end
		else
		begin
			rom_rd_reg <= (cmd.kind == OP_TABLE) && !reg_wr;
			if (cmd.kind == OP_TABLE && !reg_wr)
				rom_addr_reg <= second_reg;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tbl_reg <= '0;
		end
		else
		begin
			tbl_reg.valid <= rom_rd_reg;
			if (rom_rd_reg)
			begin
				tbl_reg.high <= rom_data[ROM_W-1:8];
				tbl_reg.low  <= rom_data[7:0];
			end
		end
	end

	// ============================================================
	// register read port, data in the cycle after the strobe
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rdata_reg <= '0;
		end
		else if (reg_rd)
		begin
			unique case (reg_addr)
				FIRST_LOC_OFF:   rdata_reg <= first_reg.loc;
				FIRST_BANK_OFF:  rdata_reg <= first_reg.bank;
				SECOND_LOC_OFF:  rdata_reg <= second_reg.loc;
				SECOND_BANK_OFF: rdata_reg <= second_reg.bank;
				PC_LOW_OFF:      rdata_reg <= pc_reg[7:0];
				PC_HIGH_OFF:     rdata_reg <= {5'h00, pc_reg[PC_W-1:8]};
				default:         rdata_reg <= 8'h00;
			endcase
		end
		else
		begin
			rdata_reg <= 8'h00;
		end
	end

	// ============================================================
	// outputs
	assign reg_rdata            = rdata_reg;
	assign pc                   = pc_reg;
	assign skip_taken           = skip_reg;
	assign result               = res_reg;
	assign first_indirect_port  = first_reg;
	assign second_indirect_port = second_reg;
	assign rom_addr             = rom_addr_reg;
	assign rom_rd               = rom_rd_reg;
	assign table_out            = tbl_reg;

	// ============================================================
	// checks
	logic quiet;
	assign quiet = !reg_wr;

	sequence s_tbl_req;
		(cmd.kind == OP_TABLE) && quiet;
	endsequence

	sequence s_tbl_fetch;
		rom_rd_reg && (rom_addr_reg == $past(second_reg));
	endsequence

	a_width_upper: assert property (@(posedge clk) disable iff (rst)
		wr_pch |=> pc_reg[PC_W-1:8] == $past(reg_wdata[PCH_W-1:0]))
		else $error("upper byte write not applied");

	a_upper_keeps_low: assert property (@(posedge clk) disable iff (rst)
		wr_pch |=> pc_reg[7:0] == $past(pc_reg[7:0]))
		else $error("upper byte write changed low byte");

	a_next_plus_one: assert property (@(posedge clk) disable iff (rst)
		(cmd.kind == OP_NEXT) && quiet |=> pc_reg == $past(pc_reg) + PC_STEP)
		else $error("counter did not advance by one");

	a_hold_still: assert property (@(posedge clk) disable iff (rst)
		(cmd.kind == OP_HOLD) && quiet |=> pc_reg == $past(pc_reg))
		else $error("counter moved while holding");

	a_table_step: assert property (@(posedge clk) disable iff (rst)
		(cmd.kind == OP_TABLE) && quiet |=> pc_reg == $past(pc_reg) + PC_STEP)
		else $error("table read did not advance by one");

	a_jump_load: assert property (@(posedge clk) disable iff (rst)
		(cmd.kind == OP_JUMP) && quiet |=> pc_reg == $past(cmd.target))
		else $error("jump target not loaded");

	a_skip_plus_two: assert property (@(posedge clk) disable iff (rst)
		is_skip && skip_hit && quiet |=> skip_reg && pc_reg == $past(pc_reg) + PC_SKIP)
		else $error("true skip did not advance by two");

	a_skip_cause: assert property (@(posedge clk) disable iff (rst)
		skip_reg |-> $past(is_skip && skip_hit && quiet))
		else $error("skip flag without a true skip");

	a_bit_skip: assert property (@(posedge clk) disable iff (rst)
		is_skip && quiet && (cmd.skip == SK_BIT_SET || cmd.skip == SK_B0_BIT_SET)
		|=> skip_reg == $past(cmd.operand[cmd.bit_sel]))
		else $error("bit set skip wrong");

	a_bit_clr_skip: assert property (@(posedge clk) disable iff (rst)
		is_skip && quiet && (cmd.skip == SK_BIT_CLR || cmd.skip == SK_B0_BIT_CLR)
		|=> skip_reg != $past(cmd.operand[cmd.bit_sel]))
		else $error("bit clear skip wrong");

	a_cmp_skip: assert property (@(posedge clk) disable iff (rst)
		is_skip && quiet && (cmd.skip == SK_CMP)
		|=> skip_reg == ($past(cmd.acc) == $past(cmd.operand)))
		else $error("compare skip wrong");

	a_inc_wrap: assert property (@(posedge clk) disable iff (rst)
		is_skip && quiet && (cmd.skip == SK_INC_MEM || cmd.skip == SK_INC_ACC)
		|=> res_reg.data == $past(inc_val) && skip_reg == (res_reg.data == 8'h00))
		else $error("increment skip wrong");

	a_dec_wrap: assert property (@(posedge clk) disable iff (rst)
		is_skip && quiet && (cmd.skip == SK_DEC_MEM || cmd.skip == SK_DEC_ACC)
		|=> res_reg.data == $past(dec_val) && skip_reg == (res_reg.data == 8'h00))
		else $error("decrement skip wrong");

	a_add_carry: assert property (@(posedge clk) disable iff (rst)
		(cmd.kind == OP_ADD_PCL) && quiet && add_sum[BYTE_W]
		|=> pc_reg[PC_W-1:8] == $past(pc_reg[PC_W-1:8]) + PCH_STEP)
		else $error("low byte carry lost");

	a_add_no_carry: assert property (@(posedge clk) disable iff (rst)
		(cmd.kind == OP_ADD_PCL) && quiet && !add_sum[BYTE_W]
		|=> pc_reg[PC_W-1:8] == $past(pc_reg[PC_W-1:8]))
		else $error("upper byte moved without carry");

	a_add_low: assert property (@(posedge clk) disable iff (rst)
		(cmd.kind == OP_ADD_PCL) && quiet |=> pc_reg[7:0] ==
		8'($past(pc_reg[7:0]) + $past(cmd.operand) + {7'h00, $past(cmd.carry_in)}))
		else $error("low byte sum wrong");

	a_sub_hold: assert property (@(posedge clk) disable iff (rst)
		(cmd.kind == OP_SUB_PCL) && quiet
		|=> pc_reg[PC_W-1:8] == $past(pc_reg[PC_W-1:8]))
		else $error("upper byte changed on subtract");

	a_sub_low: assert property (@(posedge clk) disable iff (rst)
		(cmd.kind == OP_SUB_PCL) && quiet |=> pc_reg[7:0] ==
		8'($past(pc_reg[7:0]) - $past(cmd.operand) - {7'h00, !$past(cmd.carry_in)}))
		else $error("low byte difference wrong");

	a_pcl_move: assert property (@(posedge clk) disable iff (rst)
		wr_pcl |=> pc_reg == {$past(pc_reg[PC_W-1:8]), $past(reg_wdata)})
		else $error("low byte move did not jump");

	a_ptr_write: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == FIRST_BANK_OFF
		|=> first_indirect_port.bank == $past(reg_wdata))
		else $error("first pair bank not written");

	a_ptr1_loc: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == FIRST_LOC_OFF |=> first_indirect_port.loc == $past(reg_wdata))
		else $error("first pair location not written");

	a_read_loc: assert property (@(posedge clk) disable iff (rst)
		reg_rd && reg_addr == FIRST_LOC_OFF |=> reg_rdata == $past(first_reg.loc))
		else $error("first pair location read wrong");

	a_ptr2_write: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == SECOND_LOC_OFF
		|=> second_indirect_port.loc == $past(reg_wdata))
		else $error("second pair location not written");

	a_ptr2_bank: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == SECOND_BANK_OFF |=> second_indirect_port.bank == $past(reg_wdata))
		else $error("second pair bank not written");

	a_read_bank2: assert property (@(posedge clk) disable iff (rst)
		reg_rd && reg_addr == SECOND_BANK_OFF |=> reg_rdata == $past(second_reg.bank))
		else $error("second pair bank read wrong");

	a_table_read: assert property (@(posedge clk) disable iff (rst)
		s_tbl_req |=> s_tbl_fetch ##1 tbl_reg.valid
		&& tbl_reg.high == $past(rom_data[15:8])
		&& tbl_reg.low == $past(rom_data[7:0]))
		else $error("table read sequence wrong");

	a_fetch_cause: assert property (@(posedge clk) disable iff (rst)
		rom_rd_reg |-> $past((cmd.kind == OP_TABLE) && quiet))
		else $error("program fetch without table read");

	a_valid_cause: assert property (@(posedge clk) disable iff (rst)
		tbl_reg.valid |-> $past(rom_rd_reg))
		else $error("table word without fetch");

	a_false_skip: assert property (@(posedge clk) disable iff (rst)
		is_skip && !skip_hit && quiet |=> !skip_reg && pc_reg == $past(pc_reg) + PC_STEP)
		else $error("false skip did not advance by one");

endmodule // pcp_core
`default_nettype wire

// file: verification/tb_top.sv
// self-checking testbench of the program counter and pointer block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pcp_pkg::*;
	// ==========================================================
	// signals and design
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	pcp_cmd_t          cmd = '0;
	logic [7:0]        reg_addr = 8'h00;
	logic [7:0]        reg_wdata = 8'h00;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic [ROM_W-1:0]  rom_data;
	logic [7:0]        reg_rdata;
	logic [PC_W-1:0]   pc;
	logic              skip_taken;
	pcp_res_t          result;
	pcp_ptr_t          first_p;
	pcp_ptr_t          second_p;
	logic [ROM_W-1:0]  rom_addr;
	logic              rom_rd;
	pcp_tbl_t          table_out;
	logic [PC_W-1:0]   exp_pc = '0;
	int                n_errors = 0;
	int                n_compared = 0;
	always #12.5 clk = ~clk;
	// rom model: high byte inverted location, low byte bank
	assign rom_data = {~rom_addr[7:0], rom_addr[15:8]};
	pcp_core i_dut (.clk(clk), .rst(rst), .cmd(cmd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .rom_data(rom_data),
		.reg_rdata(reg_rdata), .pc(pc), .skip_taken(skip_taken), .result(result),
		.first_indirect_port(first_p), .second_indirect_port(second_p),
		.rom_addr(rom_addr), .rom_rd(rom_rd), .table_out(table_out));
	// ==========================================================
	// shared tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic pcp_cmd_t mk(pcp_op_t k, pcp_skip_t s, logic [10:0] t,
		logic [7:0] o, logic ci);
		mk = '{kind:k, skip:s, target:t, operand:o, acc:8'h12, bit_sel:3'h5, carry_in:ci};
	endfunction
	task automatic issue(input pcp_cmd_t c);
		@(posedge clk);
		cmd <= c;
		@(posedge clk);
		cmd <= '0;
		#1;
	endtask
	task automatic jump(input logic [10:0] t);
		issue(mk(OP_JUMP, SK_CMP, t, 8'h00, 1'b0));
		exp_pc = t;
		check(pc, t);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic tally_and_finish;
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_step;
		check(pc, PC_RESET);
		jump(11'h7fe);
		issue(mk(OP_NEXT, SK_CMP, 11'h000, 8'h00, 1'b0));
		check(pc, 11'h7ff);
		issue(mk(OP_NEXT, SK_CMP, 11'h000, 8'h00, 1'b0));
		check(pc, 11'h000);
		exp_pc = 11'h000;
	endtask
	task automatic t_skips;
		for (int k = 0; k < 9; k++)
		begin
			for (int t = 0; t < 2; t++)
			begin
				pcp_skip_t sk;
				logic [7:0] op;
				sk = pcp_skip_t'(k);
				case (sk)
					SK_CMP: op = t ? 8'h12 : 8'h13;
					SK_INC_ACC, SK_INC_MEM: op = t ? 8'hff : 8'hfe;
					SK_DEC_ACC, SK_DEC_MEM: op = t ? 8'h01 : 8'h00;
					SK_BIT_CLR, SK_B0_BIT_CLR: op = t ? 8'hdf : 8'h20;
					default: op = t ? 8'h20 : 8'hdf;
				endcase
				issue(mk(OP_SKIP, sk, 11'h000, op, 1'b0));
				exp_pc = exp_pc + (t ? PC_SKIP : PC_STEP);
				check(pc, exp_pc);
				check(skip_taken, t[0]);
				if (sk == SK_INC_ACC || sk == SK_INC_MEM)
					check(result.data, 8'(op + 8'h01));
				if (sk == SK_DEC_ACC || sk == SK_DEC_MEM)
					check(result.data, 8'(op - 8'h01));
				check({result.to_acc, result.to_mem},
					{sk == SK_INC_ACC || sk == SK_DEC_ACC,
					sk == SK_INC_MEM || sk == SK_DEC_MEM});
			end
		end
	endtask
	task automatic t_arith;
		jump(11'h2f0);
		issue(mk(OP_ADD_PCL, SK_CMP, 11'h000, 8'h20, 1'b0));
		check(pc, 11'h310);
		jump(11'h7f0);
		issue(mk(OP_ADD_PCL, SK_CMP, 11'h000, 8'h20, 1'b0));
		check(pc, 11'h010);
		jump(11'h2ff);
		issue(mk(OP_ADD_PCL, SK_CMP, 11'h000, 8'h00, 1'b1));
		check(pc, 11'h300);
		jump(11'h305);
		issue(mk(OP_SUB_PCL, SK_CMP, 11'h000, 8'h10, 1'b1));
		check(pc, 11'h3f5);
		jump(11'h300);
		issue(mk(OP_SUB_PCL, SK_CMP, 11'h000, 8'h00, 1'b0));
		check(pc, 11'h3ff);
	endtask
	task automatic t_move;
		logic [7:0] d;
		jump(11'h323);
		wr(PC_LOW_OFF, 8'h28);
		check(pc, 11'h328);
		wr(PC_LOW_OFF, 8'h00);
		check(pc, 11'h300);
		rd(PC_HIGH_OFF, d);
		check(d, 8'h03);
		wr(PC_HIGH_OFF, 8'hfd);
		check(pc, 11'h500);
		rd(PC_LOW_OFF, d);
		check(d, 8'h00);
	endtask
	task automatic t_pointers;
		logic [7:0] d;
		wr(FIRST_LOC_OFF, 8'h5a);
		wr(FIRST_BANK_OFF, 8'h01);
		wr(SECOND_LOC_OFF, 8'hc3);
		wr(SECOND_BANK_OFF, 8'h02);
		rd(FIRST_LOC_OFF, d);
		check(d, 8'h5a);
		@(posedge clk);
		#1;
		check(reg_rdata, 8'h00);
		rd(FIRST_BANK_OFF, d);
		check(d, 8'h01);
		rd(SECOND_LOC_OFF, d);
		check(d, 8'hc3);
		rd(SECOND_BANK_OFF, d);
		check(d, 8'h02);
		rd(8'h82, d);
		check(d, 8'h00);
		check(first_p, 16'h015a);
		check(second_p, 16'h02c3);
	endtask
	task automatic t_table;
		issue(mk(OP_TABLE, SK_CMP, 11'h000, 8'h00, 1'b0));
		exp_pc = exp_pc + PC_STEP;
		check(pc, exp_pc);
		check(rom_rd, 1'b1);
		check(rom_addr, 16'h02c3);
		@(posedge clk);
		#1;
		check(rom_rd, 1'b0);
		check(table_out.high, 8'h3c);
		check(table_out.low, 8'h02);
		check(table_out.valid, 1'b1);
	endtask
	task automatic t_rereset;
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		#1;
		check(pc, PC_RESET);
		check(skip_taken, 1'b0);
		check(table_out.valid, 1'b0);
		check(rom_addr, 16'h0000);
		@(posedge clk);
		rst <= 1'b0;
		issue(mk(OP_NEXT, SK_CMP, 11'h000, 8'h00, 1'b0));
		check(pc, PC_RESET + PC_STEP);
	endtask
	// ==========================================================
	// main sequence
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		#1;
		t_step();
		t_skips();
		t_arith();
		t_move();
		t_pointers();
		exp_pc = 11'h500;
		t_table();
		t_rereset();
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
